//--- design/tsr_regs.sv
// Notes on behaviour
// - Eight registers, fixed reset values, indices 0-7.
// - Status, result, identity ignore writes.
// - Status is eight bits at index 0.
// - Limit flags clear on status read or return.
// - Pending bit drops when result is stored.
// - Result read sets pending bit; resets high.
// - Mode write in one-shot or sps sets pending.
// - Bit 4: below lower limit, clears above plus hysteresis.
// - Bit 5: above upper limit, clears below minus hysteresis.
// - Bit 6: above critical, clears below minus hysteresis.
// - Setup register is eight bits read/write.
// - Setup bits 1:0 give fault count one to four.
// - Setup bit 2 sets critical alert polarity.
// - Setup bit 3 sets limit alert polarity.
// - Setup bit 4: latched or comparator alerts.
// - Mode 00 converts back to back.
// - Mode 01 makes one 240 ms conversion.
// - Mode 10 converts 60 ms once per second.
// - Mode 11 stops all conversion activity.
// - Setup bit 7 selects 13 or 16 bit results.
// - Latched mode: any read releases both alerts.
// - Non-exceeding result zeroes the fault count.
// - Leaving shutdown starts a conversion at once.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module tsr_regs
	import tsr_pkg::*;
#(
	parameter int CONV_CYCLES   = CONV_CYC,
	parameter int SPS_CONV_CYCLES = SPS_CONV_CYC,
	parameter int SPS_PERIOD_CYCLES = SPS_PERIOD_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [15:0] sensorTemp,
	output logic             convActive,
	output logic             criticalAlertOut,
	output logic             limitAlertOut
);

	logic [7:0]       status;
	logic [7:0]       setup;
	logic [15:0]      tempResult;
	logic [15:0]      criticalThreshold;
	logic [7:0]       hysteresis;
	logic [15:0]      upperThreshold;
	logic [15:0]      lowerThreshold;
	tsr_state_t       cstate;
	logic [TIMER_W-1:0] timer;
	logic [1:0]       faultCnt;
	logic             critActive;
	logic             limActive;

	logic [7:0]       next_status;
	logic [7:0]       next_setup;
	logic [15:0]      next_tempResult;
	logic [15:0]      next_criticalThreshold;
	logic [7:0]       next_hysteresis;
	logic [15:0]      next_upperThreshold;
	logic [15:0]      next_lowerThreshold;
	tsr_state_t       next_cstate;
	logic [TIMER_W-1:0] next_timer;
	logic [1:0]       next_faultCnt;
	logic             next_critActive;
	logic             next_limActive;
	logic [31:0]      next_readdata;
	logic             next_waitrequest;
	logic             next_convActive;
	logic             next_criticalAlertOut;
	logic             next_limitAlertOut;

	logic             mapped;
	logic [2:0]       idx;
	logic             rdAcc;
	logic             wrAcc;
	logic             cfgWr;
	tsr_mode_t        newMode;
	tsr_mode_t        curMode;
	logic             convDone;
	logic [15:0]      tq;
	logic             overCrit;
	logic             overHigh;
	logic             underLow;
	logic             retCrit;
	logic             retHigh;
	logic             retLow;
	logic             exceed;
	logic             qualified;

	// Sign extends a result or a limit so that comparisons stay signed.
	function automatic logic signed [16:0] sx(input logic [15:0] v);
		return {v[15], v};
	endfunction

	// Hysteresis is whole degrees in the low nibble, 128 steps each.
	function automatic logic signed [16:0] hy(input logic [7:0] h);
		return {6'h00, h[3:0], 7'h00};
	endfunction

	// Byte lanes 0 and 1 update the low and high bytes of a limit.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// A timer loaded with n - 1 reaches zero n - 1 cycles later, in the nth cycle.
	function automatic logic [TIMER_W-1:0] cyc(input int n);
		return TIMER_W'(n - 1);
	endfunction

	always_comb begin
		idx      = address[IDX_MSB:IDX_LSB];
		// Only the first eight words decode; the rest read as zero.
		mapped   = (address[7:IDX_MSB+1] == 3'h0);
		rdAcc    = read & ~waitrequest;
		wrAcc    = write & ~waitrequest & mapped;
		cfgWr    = wrAcc & (idx == SETUP_IDX) & byteenable[0];
		newMode  = tsr_mode_t'(writedata[CF_MODE_MSB:CF_MODE_LSB]);
		curMode  = tsr_mode_t'(setup[CF_MODE_MSB:CF_MODE_LSB]);
		convDone = (cstate == TSR_CONV) && (timer == '0);

		// Short results compare with their extra bits taken as zero.
		tq = setup[CF_RES16] ? sensorTemp : {sensorTemp[15:3], 3'h0};
		overCrit = sx(tq) > sx(criticalThreshold);
		overHigh = sx(tq) > sx(upperThreshold);
		underLow = sx(tq) < sx(lowerThreshold);
		retCrit  = sx(tq) < sx(criticalThreshold) - hy(hysteresis);
		retHigh  = sx(tq) < sx(upperThreshold) - hy(hysteresis);
		retLow   = sx(tq) > sx(lowerThreshold) + hy(hysteresis);
		exceed    = overCrit | overHigh | underLow;
		qualified = convDone & exceed
			& (faultCnt >= setup[CF_QUEUE_MSB:CF_QUEUE_LSB]);
	end

	// Conversion sequencing.
	always_comb begin
		next_cstate = cstate;
		next_timer  = (timer != '0) ? timer - 1'b1 : timer;
		case (cstate)
			TSR_IDLE: begin
			end
			TSR_CONV: begin
				if (timer == '0) begin
					case (curMode)
						TSR_MODE_CONT: begin
							next_timer = cyc(CONV_CYCLES);
						end
						TSR_MODE_SPS: begin
							next_cstate = TSR_GAP;
							next_timer  = cyc(SPS_PERIOD_CYCLES - SPS_CONV_CYCLES);
						end
						default: begin
							next_cstate = TSR_IDLE;
						end
					endcase
				end
			end
			TSR_GAP: begin
				if (timer == '0) begin
					next_cstate = TSR_CONV;
					next_timer  = cyc(SPS_CONV_CYCLES);
				end
			end
			TSR_SHUT: begin
			end
			default: begin
				next_cstate = TSR_IDLE;
			end
		endcase
		if (cfgWr) begin
			case (newMode)
				TSR_MODE_SHUT: begin
					next_cstate = TSR_SHUT;
					next_timer  = '0;
				end
				TSR_MODE_ONE: begin
					next_cstate = TSR_CONV;
					next_timer  = cyc(CONV_CYCLES);
				end
				TSR_MODE_SPS: begin
					next_cstate = TSR_CONV;
					next_timer  = cyc(SPS_CONV_CYCLES);
				end
				default: begin
					// Rewriting mode 00 while it runs leaves the conversion alone.
					if (cstate == TSR_SHUT || cstate == TSR_IDLE ||
					    curMode != TSR_MODE_CONT) begin
						next_cstate = TSR_CONV;
						next_timer  = cyc(CONV_CYCLES);
					end
				end
			endcase
		end
	end

	// Registers, flags and alerts.
	always_comb begin
		next_setup             = setup;
		next_tempResult        = tempResult;
		next_criticalThreshold = criticalThreshold;
		next_hysteresis        = hysteresis;
		next_upperThreshold    = upperThreshold;
		next_lowerThreshold    = lowerThreshold;
		next_status            = status;
		next_faultCnt          = faultCnt;
		next_critActive        = critActive;
		next_limActive         = limActive;

		// Writes to status, result and identity fall through unchanged.
		if (wrAcc) begin
			case (idx)
				SETUP_IDX: begin
					if (byteenable[0]) begin
						next_setup = writedata[7:0];
					end
				end
				CRIT_IDX: begin
					next_criticalThreshold =
						merge16(criticalThreshold, writedata, byteenable);
				end
				HYST_IDX: begin
					if (byteenable[0]) begin
						next_hysteresis = writedata[7:0];
					end
				end
				UPPER_IDX: begin
					next_upperThreshold =
						merge16(upperThreshold, writedata, byteenable);
				end
				LOWER_IDX: begin
					next_lowerThreshold =
						merge16(lowerThreshold, writedata, byteenable);
				end
				default: begin
				end
			endcase
		end

		// Clears first, so that a flag set in the same cycle survives.
		if (rdAcc && mapped && idx == STATUS_IDX) begin
			next_status[ST_CRIT:ST_LOW] = status[ST_CRIT:ST_LOW]
				& ~readdata[ST_CRIT:ST_LOW];
		end
		if (rdAcc && mapped && idx == RESULT_IDX) begin
			next_status[ST_RDYN] = 1'b1;
		end
		if (cfgWr && (curMode == TSR_MODE_ONE || curMode == TSR_MODE_SPS ||
		    newMode == TSR_MODE_ONE || newMode == TSR_MODE_SPS)) begin
			next_status[ST_RDYN] = 1'b1;
		end
		if (rdAcc && !setup[CF_CMP_MODE]) begin
			next_critActive = 1'b0;
			next_limActive  = 1'b0;
		end

		if (convDone) begin
			next_tempResult = setup[CF_RES16] ? tq :
				{tq[15:3], overCrit, overHigh, underLow};
			next_status[ST_RDYN] = 1'b0;
			if (retLow) begin
				next_status[ST_LOW] = 1'b0;
			end
			if (retHigh) begin
				next_status[ST_HIGH] = 1'b0;
			end
			if (retCrit) begin
				next_status[ST_CRIT] = 1'b0;
			end
			if (setup[CF_CMP_MODE]) begin
				if (retCrit) begin
					next_critActive = 1'b0;
				end
				if (retHigh && retLow) begin
					next_limActive = 1'b0;
				end
			end
			// The count saturates at three, enough for the deepest queue.
			if (!exceed) begin
				next_faultCnt = 2'h0;
			end else if (faultCnt != 2'h3) begin
				next_faultCnt = faultCnt + 2'h1;
			end
			// Flags and alerts set only once the fault queue is met; the
			// set builds on the cleared value so a same-edge set wins over a clear.
			if (qualified) begin
				next_status[ST_LOW] =
					next_status[ST_LOW] | underLow;
				next_status[ST_HIGH] =
					next_status[ST_HIGH] | overHigh;
				next_status[ST_CRIT] =
					next_status[ST_CRIT] | overCrit;
				next_critActive = next_critActive | overCrit;
				next_limActive  = next_limActive | overHigh | underLow;
			end
		end
		next_status[3:0] = 4'h0;
	end

	// Bus answer: one wait cycle, then the access completes.
	// Read data are taken in the wait cycle and stand until the next read.
	always_comb begin
		next_waitrequest = ~((read | write) & waitrequest);
		next_readdata    = readdata;
		if (read && waitrequest) begin
			next_readdata = 32'h0;
			if (mapped) begin
				case (idx)
					STATUS_IDX: next_readdata[7:0]  = status;
					SETUP_IDX:  next_readdata[7:0]  = setup;
					RESULT_IDX: next_readdata[15:0] = tempResult;
					IDENT_IDX:  next_readdata[7:0]  = IDENT_VAL;
					CRIT_IDX:   next_readdata[15:0] = criticalThreshold;
					HYST_IDX:   next_readdata[7:0]  = hysteresis;
					UPPER_IDX:  next_readdata[15:0] = upperThreshold;
					LOWER_IDX:  next_readdata[15:0] = lowerThreshold;
					default:    next_readdata = 32'h0;
				endcase
			end
		end
		next_convActive       = (next_cstate == TSR_CONV);
		next_criticalAlertOut = next_critActive
			~^ next_setup[CF_CRIT_POL];
		next_limitAlertOut    = next_limActive
			~^ next_setup[CF_LIM_POL];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			status            <= STATUS_RST;
			setup             <= SETUP_RST;
			tempResult        <= RESULT_RST;
			criticalThreshold <= CRIT_RST;
			hysteresis        <= HYST_RST;
			upperThreshold    <= UPPER_RST;
			lowerThreshold    <= LOWER_RST;
			// Out of reset a conversion runs for the package CONV_CYC count, whatever CONV_CYCLES is.
			cstate            <= TSR_CONV;
			timer             <= TIMER_W'(CONV_CYC - 1);
			faultCnt          <= 2'h0;
			critActive        <= 1'b0;
			limActive         <= 1'b0;
			readdata          <= 32'h0;
			waitrequest       <= 1'b1;
			convActive        <= 1'b1;
			criticalAlertOut  <= 1'b1;
			limitAlertOut     <= 1'b1;
		end else begin
			status            <= next_status;
			setup             <= next_setup;
			tempResult        <= next_tempResult;
			criticalThreshold <= next_criticalThreshold;
			hysteresis        <= next_hysteresis;
			upperThreshold    <= next_upperThreshold;
			lowerThreshold    <= next_lowerThreshold;
			cstate            <= next_cstate;
			timer             <= next_timer;
			faultCnt          <= next_faultCnt;
			critActive        <= next_critActive;
			limActive         <= next_limActive;
			readdata          <= next_readdata;
			waitrequest       <= next_waitrequest;
			convActive        <= next_convActive;
			criticalAlertOut  <= next_criticalAlertOut;
			limitAlertOut     <= next_limitAlertOut;
		end
	end

endmodule

//--- design/tsr_pkg.sv
package tsr_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [2:0] STATUS_IDX = 3'h0;
	localparam logic [2:0] SETUP_IDX  = 3'h1;
	localparam logic [2:0] RESULT_IDX = 3'h2;
	localparam logic [2:0] IDENT_IDX  = 3'h3;
	localparam logic [2:0] CRIT_IDX   = 3'h4;
	localparam logic [2:0] HYST_IDX   = 3'h5;
	localparam logic [2:0] UPPER_IDX  = 3'h6;
	localparam logic [2:0] LOWER_IDX  = 3'h7;
	localparam int         IDX_LSB    = 2;
	localparam int         IDX_MSB    = 4;

	// Values after reset.
	localparam logic [7:0]  STATUS_RST = 8'h80;
	localparam logic [7:0]  SETUP_RST  = 8'h00;
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] CRIT_RST   = 16'h4980;
	localparam logic [7:0]  HYST_RST   = 8'h05;
	localparam logic [15:0] UPPER_RST  = 16'h2000;
	localparam logic [15:0] LOWER_RST  = 16'h0500;
	// Identification value; arbitrary neutral code.
	localparam logic [7:0]  IDENT_VAL  = 8'h5a;

	// Status bit positions.
	localparam int ST_LOW  = 4;
	localparam int ST_HIGH = 5;
	localparam int ST_CRIT = 6;
	localparam int ST_RDYN = 7;

	// Setup field positions.
	localparam int CF_QUEUE_LSB = 0;
	localparam int CF_QUEUE_MSB = 1;
	localparam int CF_CRIT_POL  = 2;
	localparam int CF_LIM_POL   = 3;
	localparam int CF_CMP_MODE  = 4;
	localparam int CF_MODE_LSB  = 5;
	localparam int CF_MODE_MSB  = 6;
	localparam int CF_RES16     = 7;

	// Hysteresis is in whole degrees; one degree is 128 result steps.
	localparam int HYST_SHIFT = 7;

	typedef enum logic [1:0] {
		TSR_MODE_CONT = 2'b00,
		TSR_MODE_ONE  = 2'b01,
		TSR_MODE_SPS  = 2'b10,
		TSR_MODE_SHUT = 2'b11
	} tsr_mode_t;

	typedef enum logic [1:0] {
		TSR_IDLE = 2'b00,
		TSR_CONV = 2'b01,
		TSR_GAP  = 2'b10,
		TSR_SHUT = 2'b11
	} tsr_state_t;

	// Timing.
	localparam longint CLK_HZ       = 250000000;
	localparam longint CONV_MS      = 240;
	localparam longint SPS_CONV_MS  = 60;
	localparam longint SPS_PERIOD_MS = 1000;
	localparam int CONV_CYC       = int'(CONV_MS * CLK_HZ / 1000);
	localparam int SPS_CONV_CYC   = int'(SPS_CONV_MS * CLK_HZ / 1000);
	localparam int SPS_PERIOD_CYC = int'(SPS_PERIOD_MS * CLK_HZ / 1000);
	localparam int TIMER_W        = 28;

endpackage

//--- verif/tsr_regs_asserts.sv
`timescale 1ns/100ps
module tsr_regs_asserts
	import tsr_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [15:0] sensorTemp,
	input wire logic        convActive,
	input wire logic        criticalAlertOut,
	input wire logic        limitAlertOut
);
	logic [7:0] setup;
	logic [7:0] next_setup;
	logic       rdDone;

	assign rdDone = read && !waitrequest;

	// Shadow of the setup register, used to predict alert levels.
	always_comb begin
		next_setup = setup;
		if (write && !waitrequest && address[7:2] == 6'h01 && byteenable[0])
			next_setup = writedata[7:0];
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			setup <= SETUP_RST;
		else
			setup <= next_setup;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_wait_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered in one cycle");
	a_unmapped_zero: assert property (
		rdDone && address[7:5] != 3'h0 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ident_fixed: assert property (
		rdDone && address[7:2] == 6'h03 |-> readdata == {24'h0, IDENT_VAL})
		else $error("identity value changed");
	a_status_unused: assert property (
		rdDone && address[7:2] == 6'h00 |->
		readdata[3:0] == 4'h0 && readdata[31:8] == 24'h0)
		else $error("status unused bits set");
	a_setup_back: assert property (
		rdDone && address[7:2] == 6'h01 |-> readdata == {24'h0, setup})
		else $error("setup readback differs");
	a_shut_still: assert property (
		setup[6:5] == 2'b11 && $past(setup[6:5]) == 2'b11 |-> !convActive)
		else $error("conversion in shutdown");
	a_shot_idle: assert property (
		setup[6:5] == 2'b01 && !convActive && !write |=> !convActive)
		else $error("one-shot restarted on its own");
	a_latch_free: assert property (
		!setup[4] && rdDone && !convActive && !$past(convActive) |=>
		criticalAlertOut == !setup[2] && limitAlertOut == !setup[3])
		else $error("latched alert not released by read");

	c_status_read: cover property (rdDone && address == 8'h00);
	c_conv_done: cover property ($fell(convActive));
	c_limit_on: cover property (limitAlertOut == setup[3]);
endmodule

bind tsr_regs tsr_regs_asserts i_tsr_regs_asserts (
	.core_clk(core_clk), .nrst(nrst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest),
	.sensorTemp(sensorTemp), .convActive(convActive),
	.criticalAlertOut(criticalAlertOut), .limitAlertOut(limitAlertOut));

//--- verif/tsr_host.sv
`timescale 1ns/100ps
module tsr_host (
	input  wire logic        core_clk,
	input  wire logic        waitrequest,
	input  wire logic [31:0] readdata,
	output logic      [7:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable
);
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'h0;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		byteenable <= 4'hf;
		write <= 1'b1;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
		writedata <= ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		address <= a;
		read <= 1'b1;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/100ps
module tb
	import tsr_pkg::*;
;
	logic        core_clk;
	logic        nrst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [15:0] sensorTemp;
	logic        convActive;
	logic        critAlert;
	logic        limAlert;
	logic [31:0] d;
	int          n_fail = 0;
	int          compares = 0;

	tsr_regs #(.CONV_CYCLES(20), .SPS_CONV_CYCLES(10),
		.SPS_PERIOD_CYCLES(50)) i_tsr_regs (
		.core_clk(core_clk), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.sensorTemp(sensorTemp), .convActive(convActive),
		.criticalAlertOut(critAlert), .limitAlertOut(limAlert));

	tsr_host i_tsr_host (
		.core_clk(core_clk), .waitrequest(waitrequest), .readdata(readdata),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		i_tsr_host.rd(a, d);
		chk(d, exp);
	endtask

	// Waits for the running conversion to finish, then lets alerts settle.
	task automatic wait_done();
		@(posedge core_clk);
		for (int k = 0; k < 100 && convActive !== 1'b0; k++)
			@(posedge core_clk);
		chk(convActive, 32'h0);
		repeat (3) @(posedge core_clk);
	endtask

	task automatic conv(input logic [7:0] cfg, input logic [15:0] t);
		sensorTemp <= t;
		i_tsr_host.wr(8'h04, {24'h0, cfg});
		wait_done();
	endtask

	task automatic t_reset();
		logic [31:0] rv [8] = '{32'h80, 32'h0, 32'h0, {24'h0, IDENT_VAL},
			32'h4980, 32'h5, 32'h2000, 32'h500};
		for (int i = 0; i < 8; i++)
			rdchk(8'(i * 4), rv[i]);
		rdchk(8'h20, 32'h0);
		i_tsr_host.wr(8'h00, 32'hff);
		i_tsr_host.wr(8'h08, 32'hffff);
		i_tsr_host.wr(8'h0c, 32'hff);
		i_tsr_host.wr(8'h40, 32'hff);
		rdchk(8'h00, 32'h80);
		rdchk(8'h08, 32'h0);
		rdchk(8'h0c, {24'h0, IDENT_VAL});
		rdchk(8'h04, 32'h0);
		i_tsr_host.wr(8'h18, 32'h0800);
		i_tsr_host.wr(8'h1c, 32'h0000);
		rdchk(8'h18, 32'h0800);
		$display("test reset and read-only done");
	endtask

	task automatic t_oneshot();
		conv(8'h20, 16'h0600);
		rdchk(8'h00, 32'h00);
		rdchk(8'h08, 32'h0600);
		rdchk(8'h00, 32'h80);
		repeat (30) @(posedge core_clk);
		chk(convActive, 32'h0);
		$display("test one-shot done");
	endtask

	task automatic t_queue();
		conv(8'h21, 16'h1000);
		chk(limAlert, 32'h1);
		conv(8'h21, 16'h1000);
		chk(limAlert, 32'h0);
		chk(critAlert, 32'h1);
		rdchk(8'h00, 32'h20);
		repeat (2) @(posedge core_clk);
		chk(limAlert, 32'h1);
		rdchk(8'h00, 32'h00);
		i_tsr_host.wr(8'h04, 32'h21);
		rdchk(8'h00, 32'h80);
		wait_done();
		rdchk(8'h08, 32'h1002);
		$display("test fault queue done");
	endtask

	task automatic t_compare();
		conv(8'h30, 16'h1000);
		rdchk(8'h00, 32'h20);
		chk(limAlert, 32'h0);
		conv(8'h30, 16'h0400);
		chk(limAlert, 32'h1);
		rdchk(8'h00, 32'h00);
		i_tsr_host.wr(8'h10, 32'h0c00);
		conv(8'h2c, 16'h1000);
		chk(critAlert, 32'h1);
		chk(limAlert, 32'h1);
		rdchk(8'h00, 32'h60);
		conv(8'ha0, 16'h1003);
		rdchk(8'h08, 32'h1003);
		$display("test comparator and polarity done");
	endtask

	task automatic t_modes();
		i_tsr_host.wr(8'h04, 32'h60);
		repeat (30) @(posedge core_clk);
		chk(convActive, 32'h0);
		rdchk(8'h08, 32'h1003);
		i_tsr_host.wr(8'h04, 32'h00);
		@(posedge core_clk);
		chk(convActive, 32'h1);
		repeat (25) @(posedge core_clk);
		rdchk(8'h08, 32'h1006);
		repeat (25) @(posedge core_clk);
		rdchk(8'h00, 32'h60);
		chk(convActive, 32'h1);
		i_tsr_host.wr(8'h04, 32'h40);
		wait_done();
		repeat (20) @(posedge core_clk);
		chk(convActive, 32'h0);
		for (int k = 0; k < 40 && convActive !== 1'b1; k++)
			@(posedge core_clk);
		chk(convActive, 32'h1);
		$display("test conversion modes done");
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end

	initial begin
		nrst = 1'b0;
		sensorTemp = 16'h0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_oneshot();
		t_queue();
		t_compare();
		t_modes();
		end_of_test();
	end
endmodule
